// file: hdl/mcr_pkg.sv
// Purpose: Constants for the core register set of the 8-bit controller.
// Assumes: APB byte address = register index * 4, 32-bit data, 8 bits used.
// Notes:   Parity is not stored; it is derived from the accumulator.
//
// How it works
// - Accumulator is 8 bits, resets to zero, main operand and result.
// - Multiply/divide operand register, also scratch, resets to zero.
// - Status bit 7 is carry and the Boolean single-bit accumulator.
// - Status bit 6 is set on carry out of accumulator bit 3.
// - Status bits 5 and 1 are plain user flags, no side effect.
// - Status bits 4-3 pick bank base 0x00, 0x08, 0x10 or 0x18.
// - Status bit 2 is set on signed accumulator overflow.
// - Status bit 0 always shows odd parity of the accumulator.
// - Only hardware sets parity; software writes to it do nothing.
// - Stack pointer resets to 0x07, pre-increments on push, post-decrements.
// - Return address goes onto the internal-RAM stack before the routine.
// - Select bit 0 picks pointer pair 0 or 1; bits 7:1 unused.
// - Active pointer gives the 16-bit indirect address.
// - Each pointer is one 16-bit register or two byte registers.
// - Internal RAM is 256 bytes; upper 128 only indirectly addressed.
// - 2048-byte RAM decoded at 0x8000 to 0x87FF, for data and code.
// - Both pointers and the select register reset to zero.
package mcr_pkg;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PADDR_W  = 12;
  localparam int unsigned IDX_W    = 8;

  // Register indices; byte address is index times four
  localparam logic [7:0] IDX_STACK_TOP  = 8'h81;
  localparam logic [7:0] IDX_PTR0_LOW   = 8'h82;
  localparam logic [7:0] IDX_PTR0_HIGH  = 8'h83;
  localparam logic [7:0] IDX_PTR1_LOW   = 8'h84;
  localparam logic [7:0] IDX_PTR1_HIGH  = 8'h85;
  localparam logic [7:0] IDX_PTR_SELECT = 8'h92;
  localparam logic [7:0] IDX_STATUS     = 8'hd0;
  localparam logic [7:0] IDX_ACC        = 8'he0;
  localparam logic [7:0] IDX_MULDIV     = 8'hf0;

  // Reset values
  localparam logic [7:0] RST_STACK_TOP = 8'h07;
  localparam logic [7:0] RST_ZERO      = 8'h00;

  // Status word bit positions
  localparam int unsigned ST_CARRY  = 7;
  localparam int unsigned ST_HALF   = 6;
  localparam int unsigned ST_USER0  = 5;
  localparam int unsigned ST_BANK_H = 4;
  localparam int unsigned ST_BANK_L = 3;
  localparam int unsigned ST_OVF    = 2;
  localparam int unsigned ST_USER1  = 1;
  localparam int unsigned ST_PARITY = 0;
  localparam int unsigned SEL_BIT   = 0;

  // Memory map
  localparam int unsigned INTERNAL_SCRATCH_RAM_DEPTH = 256;
  localparam int unsigned XRAM_DEPTH = 2048;
  localparam int unsigned XRAM_AW    = 11;
  localparam logic [15:0] XRAM_BASE  = 16'h8000;
  localparam logic [15:0] XRAM_LAST  = 16'h87ff;
  localparam int unsigned INTERNAL_SCRATCH_RAM_UPPER = 7;
endpackage

// file: hdl/mcr_internal_scratch_ram.sv
// Purpose: 256-byte internal scratch RAM with one write and two read ports.
// Assumes: Reads are combinational, writes take effect at the clock edge.
// Notes:   Contents are not reset, as with any real RAM.
`timescale 1ns/1ps
module mcr_internal_scratch_ram (
  input  wire logic       pclk,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] raddr_a,
  output logic      [7:0] rdata_a,
  input  wire logic [7:0] raddr_b,
  output logic      [7:0] rdata_b
);
  logic [7:0] mem [mcr_pkg::INTERNAL_SCRATCH_RAM_DEPTH];

  // Single write port; no reset so it maps onto a plain RAM macro
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Two independent read ports: core access and stack pop
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule

// file: hdl/mcr_xram.sv
// Purpose: 2048-byte data/code RAM in the external-data space.
// Assumes: 16-bit address from the core; only the fixed window responds.
// Notes:   Outside the window reads give zero and writes are dropped.
`timescale 1ns/1ps
module mcr_xram (
  input  wire logic        pclk,
  input  wire logic [15:0] addr,
  input  wire logic        we,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  output logic             hit
);
  logic [7:0] mem [mcr_pkg::XRAM_DEPTH];
  wire  [mcr_pkg::XRAM_AW-1:0] offset = addr[mcr_pkg::XRAM_AW-1:0];

  // Fixed decode of the window
  assign hit = (addr >= mcr_pkg::XRAM_BASE) &&
               (addr <= mcr_pkg::XRAM_LAST);

  always_ff @(posedge pclk) begin
    if (we && hit) begin
      mem[offset] <= wdata;
    end
  end

  assign rdata = hit ? mem[offset] : 8'h00;
endmodule

// file: hdl/mcr_core_regs.sv
// Purpose: Programmer-visible core registers, stack and RAM map of the MCU.
// Assumes: One clock; core strobes are one-cycle pulses on pclk.
// Notes:   APB writes win over core updates of the same register.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module mcr_core_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Execution unit: accumulator and operand register
  input  wire logic        core_acc_we,
  input  wire logic [7:0]  core_acc_d,
  input  wire logic        core_muldiv_we,
  input  wire logic [7:0]  core_muldiv_d,
  // Execution unit: flags written with the result
  input  wire logic        core_carry_we,
  input  wire logic        core_carry_d,
  input  wire logic        core_half_we,
  input  wire logic        core_half_d,
  input  wire logic        core_ovf_we,
  input  wire logic        core_ovf_d,
  // Execution unit: stack
  input  wire logic        core_push,
  input  wire logic [7:0]  core_push_data,
  input  wire logic        core_pop,
  output logic      [7:0]  core_pop_data,
  // Execution unit: data pointer
  input  wire logic        core_ptr_we,
  input  wire logic [15:0] core_ptr_d,
  output logic      [15:0] active_pointer,
  // Execution unit: internal RAM
  input  wire logic [7:0]  core_ram_addr,
  input  wire logic        core_ram_indirect,
  input  wire logic        core_ram_we,
  input  wire logic [7:0]  core_ram_wdata,
  output logic      [7:0]  core_ram_rdata,
  output logic             core_ram_refused,
  // Execution unit: external-data RAM
  input  wire logic [15:0] core_x_addr,
  input  wire logic        core_x_we,
  input  wire logic [7:0]  core_x_wdata,
  output logic      [7:0]  core_x_rdata,
  output logic             core_x_hit,
  // State seen by the core
  output logic      [7:0]  accumulator,
  output logic      [7:0]  multiply_divide_operand,
  output logic      [7:0]  program_status_word,
  output logic      [7:0]  stack_top_pointer,
  output logic      [7:0]  bank_base
);

  // Register state
  logic [7:0] acc_q, acc_d;
  logic [7:0] muldiv_q, muldiv_d;
  logic [7:0] sp_q, sp_d;
  logic [7:0] p0_low_q, p0_low_d;
  logic [7:0] p0_high_q, p0_high_d;
  logic [7:0] p1_low_q, p1_low_d;
  logic [7:0] p1_high_q, p1_high_d;
  logic       sel_q, sel_d;
  logic       carry_q, carry_d;
  logic       half_q, half_d;
  logic       user0_q, user0_d;
  logic [1:0] bank_q, bank_d;
  logic       ovf_q, ovf_d;
  logic       user1_q, user1_d;

  // APB address decode; index sits in paddr[9:2]
  wire [7:0] apb_idx    = paddr[9:2];
  wire       apb_align  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  wire       hit_sp     = apb_align && (apb_idx == mcr_pkg::IDX_STACK_TOP);
  wire       hit_p0l    = apb_align && (apb_idx == mcr_pkg::IDX_PTR0_LOW);
  wire       hit_p0h    = apb_align && (apb_idx == mcr_pkg::IDX_PTR0_HIGH);
  wire       hit_p1l    = apb_align && (apb_idx == mcr_pkg::IDX_PTR1_LOW);
  wire       hit_p1h    = apb_align && (apb_idx == mcr_pkg::IDX_PTR1_HIGH);
  wire       hit_sel    = apb_align && (apb_idx == mcr_pkg::IDX_PTR_SELECT);
  wire       hit_st     = apb_align && (apb_idx == mcr_pkg::IDX_STATUS);
  wire       hit_acc    = apb_align && (apb_idx == mcr_pkg::IDX_ACC);
  wire       hit_md     = apb_align && (apb_idx == mcr_pkg::IDX_MULDIV);
  wire       apb_hit    = hit_sp | hit_p0l | hit_p0h | hit_p1l | hit_p1h |
                          hit_sel | hit_st | hit_acc | hit_md;
  wire       apb_access = psel && penable;
  wire       apb_wr     = apb_access && pwrite && apb_hit;
  wire [7:0] wbyte      = pwdata[7:0];

  // Per-register write strobes
  wire wr_sp  = apb_wr && hit_sp;
  wire wr_p0l = apb_wr && hit_p0l;
  wire wr_p0h = apb_wr && hit_p0h;
  wire wr_p1l = apb_wr && hit_p1l;
  wire wr_p1h = apb_wr && hit_p1h;
  wire wr_sel = apb_wr && hit_sel;
  wire wr_st  = apb_wr && hit_st;
  wire wr_acc = apb_wr && hit_acc;
  wire wr_md  = apb_wr && hit_md;

  // Zero-wait slave; unmapped or misaligned addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = apb_access && !apb_hit;

  // Parity is a pure function of the accumulator, so it can never go stale
  wire parity = ^acc_q;

  // Status word assembled from its fields; parity slot never stored
  assign program_status_word = {carry_q, half_q, user0_q, bank_q,
                                ovf_q, user1_q, parity};

  // Accumulator and operand register: bus write first, then core result
  assign acc_d = wr_acc      ? wbyte :
                 core_acc_we ? core_acc_d : acc_q;
  assign muldiv_d = wr_md          ? wbyte :
                    core_muldiv_we ? core_muldiv_d : muldiv_q;

  // Flags load in the same edge as the result, so the next op sees both
  assign carry_d = wr_st         ? wbyte[mcr_pkg::ST_CARRY] :
                   core_carry_we ? core_carry_d : carry_q;
  assign half_d  = wr_st         ? wbyte[mcr_pkg::ST_HALF] :
                   core_half_we  ? core_half_d : half_q;
  assign ovf_d   = wr_st         ? wbyte[mcr_pkg::ST_OVF] :
                   core_ovf_we   ? core_ovf_d : ovf_q;
  assign user0_d = wr_st ? wbyte[mcr_pkg::ST_USER0] : user0_q;
  assign user1_d = wr_st ? wbyte[mcr_pkg::ST_USER1] : user1_q;
  assign bank_d  = wr_st ? wbyte[mcr_pkg::ST_BANK_H:mcr_pkg::ST_BANK_L]
                         : bank_q;

  // Working bank base: field value times eight
  assign bank_base = {3'b000, bank_q, 3'b000};

  // Stack: pre-increment on push, post-decrement on pop
  wire [7:0] sp_inc = sp_q + 8'h01;
  wire [7:0] sp_dec = sp_q - 8'h01;
  assign sp_d = wr_sp     ? wbyte  :
                core_push ? sp_inc :
                core_pop  ? sp_dec : sp_q;

  // Data pointers: byte access from the bus, 16-bit load from the core
  wire core_p0 = core_ptr_we && !sel_q;
  wire core_p1 = core_ptr_we &&  sel_q;
  assign p0_low_d  = wr_p0l  ? wbyte :
                     core_p0 ? core_ptr_d[7:0] : p0_low_q;
  assign p0_high_d = wr_p0h  ? wbyte :
                     core_p0 ? core_ptr_d[15:8] : p0_high_q;
  assign p1_low_d  = wr_p1l  ? wbyte :
                     core_p1 ? core_ptr_d[7:0] : p1_low_q;
  assign p1_high_d = wr_p1h  ? wbyte :
                     core_p1 ? core_ptr_d[15:8] : p1_high_q;
  assign sel_d = wr_sel ? wbyte[mcr_pkg::SEL_BIT] : sel_q;

  // Active pointer drives indirect external, code and branch addresses
  assign active_pointer = sel_q ? {p1_high_q, p1_low_q}
                                : {p0_high_q, p0_low_q};

  // Core-visible copies of the stored registers
  assign accumulator             = acc_q;
  assign multiply_divide_operand = muldiv_q;
  assign stack_top_pointer       = sp_q;

  // Stored registers; pointer pair 1 is also cleared to keep it defined
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q     <= mcr_pkg::RST_ZERO;
      muldiv_q  <= mcr_pkg::RST_ZERO;
      sp_q      <= mcr_pkg::RST_STACK_TOP;
      p0_low_q  <= mcr_pkg::RST_ZERO;
      p0_high_q <= mcr_pkg::RST_ZERO;
      p1_low_q  <= mcr_pkg::RST_ZERO;
      p1_high_q <= mcr_pkg::RST_ZERO;
      sel_q     <= 1'b0;
    end else begin
      acc_q     <= acc_d;
      muldiv_q  <= muldiv_d;
      sp_q      <= sp_d;
      p0_low_q  <= p0_low_d;
      p0_high_q <= p0_high_d;
      p1_low_q  <= p1_low_d;
      p1_high_q <= p1_high_d;
      sel_q     <= sel_d;
    end
  end

  // Status fields; all clear at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_q <= 1'b0;
      half_q  <= 1'b0;
      user0_q <= 1'b0;
      bank_q  <= 2'b00;
      ovf_q   <= 1'b0;
      user1_q <= 1'b0;
    end else begin
      carry_q <= carry_d;
      half_q  <= half_d;
      user0_q <= user0_d;
      bank_q  <= bank_d;
      ovf_q   <= ovf_d;
      user1_q <= user1_d;
    end
  end

  // APB read mux; unused upper bits and the select's spare bits read zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_sp) begin
      rd_byte = sp_q;
    end
    if (hit_p0l) begin
      rd_byte = p0_low_q;
    end
    if (hit_p0h) begin
      rd_byte = p0_high_q;
    end
    if (hit_p1l) begin
      rd_byte = p1_low_q;
    end
    if (hit_p1h) begin
      rd_byte = p1_high_q;
    end
    if (hit_sel) begin
      rd_byte = {7'h00, sel_q};
    end
    if (hit_st) begin
      rd_byte = program_status_word;
    end
    if (hit_acc) begin
      rd_byte = acc_q;
    end
    if (hit_md) begin
      rd_byte = muldiv_q;
    end
  end
  assign prdata = (apb_access && !pwrite) ? {24'h000000, rd_byte}
                                          : 32'h00000000;

  // Internal RAM: direct access to the upper half is refused
  wire ram_upper = core_ram_addr[mcr_pkg::INTERNAL_SCRATCH_RAM_UPPER];
  assign core_ram_refused = !core_ram_indirect && ram_upper;
  wire ram_wr_ok = core_ram_we && !core_ram_refused;

  // Pushed bytes (return addresses included) land at the new stack top
  wire       internal_scratch_ram_we    = core_push || ram_wr_ok;
  wire [7:0] internal_scratch_ram_waddr = core_push ? sp_inc : core_ram_addr;
  wire [7:0] internal_scratch_ram_wdata = core_push ? core_push_data
                                    : core_ram_wdata;
  wire [7:0] internal_scratch_ram_rd;

  // A push takes the single write port; a same-cycle core write is lost,
  // which the sequencer never issues since both come from one instruction
  mcr_internal_scratch_ram u_internal_scratch_ram (
    .pclk    (pclk),
    .we      (internal_scratch_ram_we),
    .waddr   (internal_scratch_ram_waddr),
    .wdata   (internal_scratch_ram_wdata),
    .raddr_a (core_ram_addr),
    .rdata_a (internal_scratch_ram_rd),
    .raddr_b (sp_q),
    .rdata_b (core_pop_data)
  );

  assign core_ram_rdata = core_ram_refused ? 8'h00 : internal_scratch_ram_rd;

  // External-data RAM window, shared by data moves and code fetch
  mcr_xram u_xram (
    .pclk  (pclk),
    .addr  (core_x_addr),
    .we    (core_x_we),
    .wdata (core_x_wdata),
    .rdata (core_x_rdata),
    .hit   (core_x_hit)
  );

endmodule

// file: dv/mcr_core_regs_chk.sv
// Purpose: Port-level assertions for the core register set.
// Assumes: Only the ports of mcr_core_regs are visible here.
// Notes:   APB writes win over core strobes, so those edges are skipped.
`timescale 1ns/1ps
module mcr_core_regs_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_acc_we,
  input wire logic [7:0]  core_acc_d,
  input wire logic        core_carry_we,
  input wire logic        core_carry_d,
  input wire logic        core_push,
  input wire logic        core_pop,
  input wire logic        core_ptr_we,
  input wire logic [15:0] core_ptr_d,
  input wire logic [15:0] active_pointer,
  input wire logic [7:0]  core_ram_addr,
  input wire logic        core_ram_indirect,
  input wire logic        core_ram_refused,
  input wire logic [15:0] core_x_addr,
  input wire logic        core_x_hit,
  input wire logic [7:0]  accumulator,
  input wire logic [7:0]  program_status_word,
  input wire logic [7:0]  stack_top_pointer,
  input wire logic [7:0]  bank_base
);
  // Any APB write edge may override a core update
  wire apb_wr = psel && penable && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_parity_live: assert property (
    program_status_word[0] == ^accumulator) else $error("parity bad");
  chk_bank_base: assert property (
    bank_base == {3'h0, program_status_word[4:3], 3'h0})
    else $error("bank base bad");
  chk_acc_load: assert property (
    core_acc_we && !apb_wr |=> accumulator == $past(core_acc_d))
    else $error("acc load bad");
  chk_carry_load: assert property (
    core_carry_we && !apb_wr |=> program_status_word[7] == $past(core_carry_d))
    else $error("carry load bad");
  chk_push_incr: assert property (
    core_push && !apb_wr
    |=> stack_top_pointer == $past(stack_top_pointer) + 8'h1)
    else $error("push sp bad");
  chk_pop_decr: assert property (
    core_pop && !core_push && !apb_wr
    |=> stack_top_pointer == $past(stack_top_pointer) - 8'h1)
    else $error("pop sp bad");
  chk_ptr_load: assert property (
    core_ptr_we && !apb_wr |=> active_pointer == $past(core_ptr_d))
    else $error("pointer load bad");
  chk_direct_upper: assert property (
    core_ram_refused == (!core_ram_indirect && core_ram_addr[7]))
    else $error("refusal bad");
  chk_xram_window: assert property (
    core_x_hit == (core_x_addr >= 16'h8000 && core_x_addr <= 16'h87ff))
    else $error("xram decode bad");
  chk_zero_wait: assert property (
    psel && penable && paddr[1:0] != 2'h0 |-> pready && pslverr)
    else $error("misaligned answer bad");
endmodule

bind mcr_core_regs mcr_core_regs_chk u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pready, .pslverr, .core_acc_we, .core_acc_d,
  .core_carry_we, .core_carry_d, .core_push, .core_pop, .core_ptr_we,
  .core_ptr_d, .active_pointer, .core_ram_addr, .core_ram_indirect,
  .core_ram_refused, .core_x_addr, .core_x_hit, .accumulator,
  .program_status_word, .stack_top_pointer, .bank_base);

// file: dv/mcr_exec_model.sv
// Purpose: Execution-unit stand-in that runs call and return stack traffic.
// Assumes: Tasks are called from the bench; strobes change after rising edges.
// Notes:   Push data idles at the inverse of its last byte.
`timescale 1ns/1ps
module mcr_exec_model (
  input  wire logic       pclk,
  input  wire logic [7:0] core_pop_data,
  output logic            core_push = 1'h0,
  output logic      [7:0] core_push_data = 8'h00,
  output logic            core_pop = 1'h0
);
  // Call saves the return address, low byte first, before the routine
  task automatic do_call(input logic [15:0] a);
    @(posedge pclk);
    core_push <= 1'h1;
    core_push_data <= a[7:0];
    @(posedge pclk);
    core_push_data <= a[15:8];
    @(posedge pclk);
    core_push <= 1'h0;
    core_push_data <= ~a[15:8];
  endtask
  // Return reads the top of stack before each decrement lands
  task automatic do_ret(output logic [15:0] a);
    @(posedge pclk);
    core_pop <= 1'h1;
    @(posedge pclk);
    a[15:8] = core_pop_data;
    @(posedge pclk);
    a[7:0] = core_pop_data;
    core_pop <= 1'h0;
  endtask
endmodule

// file: dv/tb_mcu_core_register_set.sv
// Purpose: Self-checking bench for the core register set.
// Assumes: APB answers in the first access cycle or later.
// Notes:   A small register model predicts every register read.
`timescale 1ns/1ps
module tb_mcu_core_register_set;
  logic        pclk = 1'h0, presetn = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e, hf;
  logic        core_acc_we = 1'h0, core_muldiv_we = 1'h0;
  logic        core_carry_we = 1'h0, core_half_we = 1'h0;
  logic        core_ovf_we = 1'h0, core_ptr_we = 1'h0;
  logic        core_carry_d = 1'h0, core_half_d = 1'h0, core_ovf_d = 1'h0;
  logic [7:0]  core_acc_d = 8'h00, core_muldiv_d = 8'h00;
  logic [15:0] core_ptr_d = 16'h0, core_x_addr = 16'h0, active_pointer, ra;
  logic        core_ram_indirect = 1'h0, core_ram_we = 1'h0, core_x_we = 1'h0;
  logic [7:0]  core_ram_addr = 8'h00, core_ram_wdata = 8'h00;
  logic [7:0]  core_x_wdata = 8'h00, q, v, core_ram_rdata, core_x_rdata;
  logic        core_push, core_pop, core_ram_refused, core_x_hit;
  logic [7:0]  core_push_data, core_pop_data, accumulator, bank_base;
  logic [7:0]  multiply_divide_operand, program_status_word, stack_top_pointer;
  logic [31:0] seed = 32'h8044c954;
  logic [11:0] adr [9] = '{12'h204, 12'h208, 12'h20c, 12'h210, 12'h214,
                           12'h248, 12'h340, 12'h380, 12'h3c0};
  logic [7:0]  m   [9] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h00, 8'h00, 8'h00, 8'h00};
  int          err_count = 0, num_checks = 0;

  always #50 pclk = ~pclk;
  mcr_core_regs dut (.*);
  mcr_exec_model u_exec (.pclk, .core_pop_data, .core_push, .core_push_data,
                         .core_pop);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Select keeps only bit 0; parity always comes from the accumulator
  function automatic logic [7:0] expv(int i);
    if (i == 5) return m[5] & 8'h01;
    if (i == 6) return {m[6][7:1], ^m[7]};
    return m[i];
  endfunction
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", n, x, g);
      err_count++;
    end
  endtask
  // Request held until pready is sampled high, data taken at that edge
  task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(int i);
    apb(1'h0, adr[i], 8'h00);
    chk($sformatf("reg%0d", i), {24'h0, expv(i)}, r);
  endtask
  task automatic wr(int i, logic [7:0] d);
    apb(1'h1, adr[i], d);
    m[i] = d;
  endtask
  task automatic ram(logic w, logic ind, logic [7:0] a, logic [7:0] d);
    @(posedge pclk);
    core_ram_we <= w;
    core_ram_indirect <= ind;
    core_ram_addr <= a;
    core_ram_wdata <= d;
    @(negedge pclk);
    q = core_ram_rdata;
    hf = core_ram_refused;
    @(posedge pclk);
    core_ram_we <= 1'h0;
  endtask
  task automatic xm(logic w, logic [15:0] a, logic [7:0] d);
    @(posedge pclk);
    core_x_we <= w;
    core_x_addr <= a;
    core_x_wdata <= d;
    @(negedge pclk);
    q = core_x_rdata;
    hf = core_x_hit;
    @(posedge pclk);
    core_x_we <= 1'h0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #2000000;
    err_count++;
    $display("Error watchdog expected done seen hang");
    results();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 9; i++) rd(i);
    $display("test reset values done");
    apb(1'h1, 12'h382, 8'h55);
    chk("misaligned slverr", 1, e);
    apb(1'h0, 12'h3fc, 8'h00);
    chk("unmapped slverr", 1, e);
    chk("unmapped rdata", 0, r);
    rd(7);
    $display("test refused access done");
    repeat (3) for (int i = 0; i < 9; i++) wr(i, rnd());
    for (int i = 0; i < 9; i++) rd(i);
    $display("test register access done");
    for (int b = 0; b < 4; b++) begin
      wr(6, {3'h7, b[1:0], 3'h5});
      @(negedge pclk);
      chk("bank_base", {b[1:0], 3'h0}, bank_base);
    end
    $display("test bank select done");
    // Flags and results land in the same edge as the accumulator
    for (int k = 0; k < 8; k++) begin
      v = rnd();
      @(posedge pclk);
      core_acc_we <= 1'h1;
      core_acc_d <= v;
      core_muldiv_we <= 1'h1;
      core_muldiv_d <= ~v;
      {core_carry_we, core_half_we, core_ovf_we} <= k[2:0];
      {core_carry_d, core_half_d, core_ovf_d} <= v[7:5];
      @(posedge pclk);
      {core_acc_we, core_muldiv_we} <= 2'h0;
      {core_carry_we, core_half_we, core_ovf_we} <= 3'h0;
      m[7] = v;
      m[8] = ~v;
      if (k[2]) m[6][7] = v[7];
      if (k[1]) m[6][6] = v[6];
      if (k[0]) m[6][2] = v[5];
      rd(6);
      rd(7);
      rd(8);
      chk("operand port", m[8], multiply_divide_operand);
    end
    $display("test core flags done");
    for (int s = 0; s < 2; s++) begin
      wr(5, {7'h7f, s[0]});
      @(negedge pclk);
      chk("active", s ? {m[4], m[3]} : {m[2], m[1]}, active_pointer);
      ra = rnd();
      @(posedge pclk);
      core_ptr_we <= 1'h1;
      core_ptr_d <= ra;
      @(posedge pclk);
      core_ptr_we <= 1'h0;
      {m[2 + 2 * s], m[1 + 2 * s]} = ra;
      for (int i = 1; i < 5; i++) rd(i);
    end
    $display("test data pointers done");
    wr(0, 8'h2f);
    ra = rnd();
    u_exec.do_call(ra);
    m[0] = 8'h31;
    rd(0);
    ram(1'h0, 1'h1, 8'h30, 8'h00);
    chk("stack low", ra[7:0], q);
    ram(1'h0, 1'h1, 8'h31, 8'h00);
    chk("stack high", ra[15:8], q);
    u_exec.do_ret(r[15:0]);
    chk("return addr", ra, r[15:0]);
    m[0] = 8'h2f;
    rd(0);
    $display("test call return done");
    ram(1'h1, 1'h1, 8'h90, 8'hc3);
    ram(1'h0, 1'h1, 8'h90, 8'h00);
    chk("upper indirect", 8'hc3, q);
    ram(1'h0, 1'h0, 8'h90, 8'h00);
    chk("upper direct refused", 1, hf);
    chk("upper direct data", 0, q);
    ram(1'h1, 1'h0, 8'h10, 8'h3c);
    ram(1'h0, 1'h0, 8'h10, 8'h00);
    chk("lower direct", 9'h03c, {hf, q});
    $display("test internal ram done");
    xm(1'h1, 16'h8000, 8'ha5);
    xm(1'h1, 16'h87ff, 8'h5a);
    xm(1'h1, 16'h8800, 8'hff);
    xm(1'h0, 16'h8000, 8'h00);
    chk("xram base", 8'ha5, q);
    xm(1'h0, 16'h87ff, 8'h00);
    chk("xram last", 9'h15a, {hf, q});
    xm(1'h0, 16'h8800, 8'h00);
    chk("xram outside", 0, {hf, q});
    $display("test external ram done");
    results();
  end
endmodule
